// *** logic/oiq_map.svh ***
`ifndef OIQ_MAP_SVH
`define OIQ_MAP_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define OIQ_NPORT 8
`define OIQ_PORT_W 3
`define OIQ_NQ 3
`define OIQ_QDEPTH 8
`define OIQ_PTR_W 3
`define OIQ_CNT_W 4
`define OIQ_NCLASS 16
`define OIQ_LEN_W 11
`define OIQ_DROP_W 16
`define OIQ_BUCKET_W 16
`define OIQ_RATE_W 8

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define OIQ_REG_CTRL 8'h00
`define OIQ_REG_IRQ_STATUS 8'h01
`define OIQ_REG_IRQ_MASK 8'h02
`define OIQ_REG_POLICY 8'h03
`define OIQ_REG_NETPORT 8'h04
`define OIQ_REG_QLEVEL 8'h05
`define OIQ_REG_CMAP_LO 8'h06
`define OIQ_REG_CMAP_HI 8'h07
`define OIQ_REG_THR0 8'h08
`define OIQ_REG_THR1 8'h09
`define OIQ_REG_THR2 8'h0A
`define OIQ_REG_RATE_BASE 4'h2
`define OIQ_REG_DROP_BASE 4'h3

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define OIQ_CTRL_EN_BIT 0
`define OIQ_IRQ_RATE_BIT 0
`define OIQ_IRQ_QDROP_BIT 1
`define OIQ_CTRL_RST 1'h1
`define OIQ_POLICY_RST 16'h0000
`define OIQ_NETPORT_RST 8'h00
`define OIQ_CMAP_LO_RST 32'h4567_89AB
`define OIQ_CMAP_HI_RST 32'h0011_2233
`define OIQ_THR_RST 16'h8642
`define OIQ_RATE_RST 8'hFF
`define OIQ_BURST_RST 16'hFFFF
`define OIQ_NC_CLASS 4'h0
`define OIQ_BE_CLASS 4'hE
`define OIQ_RATE_TICK 1

`endif

// *** logic/oiq_pkg.sv ***
`include "oiq_map.svh"

package oiq_pkg;

    typedef enum logic [1:0] {
        OIQ_POL_DEFAULT = 2'b00,
        OIQ_POL_DOT1P = 2'b01,
        OIQ_POL_DSCP = 2'b10,
        OIQ_POL_FILTER = 2'b11
    } oiq_policy_t;

    typedef struct packed {
        logic [`OIQ_PORT_W-1:0] port;
        logic [`OIQ_LEN_W-1:0] len;
        logic [2:0] dot1p;
        logic dei;
        logic [5:0] dscp;
        logic local_addr;
    } oiq_pkt_t;

    typedef struct packed {
        logic [`OIQ_PORT_W-1:0] port;
        logic [`OIQ_LEN_W-1:0] len;
    } oiq_ent_t;

    typedef struct packed {
        logic enable;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [`OIQ_NPORT-1:0][1:0] policy;
        logic [`OIQ_NPORT-1:0] netport;
        logic [`OIQ_NQ-1:0][3:0][`OIQ_CNT_W-1:0] thr;
        logic [`OIQ_NCLASS-1:0][3:0] cmap;
        logic [`OIQ_NPORT-1:0][`OIQ_RATE_W-1:0] rate;
        logic [`OIQ_NPORT-1:0][`OIQ_BUCKET_W-1:0] burst;
        logic [`OIQ_NPORT-1:0][`OIQ_BUCKET_W-1:0] bucket;
        logic [15:0] tick;
        logic [`OIQ_NCLASS-1:0][`OIQ_DROP_W-1:0] drop;
        logic [`OIQ_NQ-1:0][`OIQ_QDEPTH-1:0] mem_vld;
        logic [`OIQ_NQ-1:0][`OIQ_QDEPTH-1:0][$bits(oiq_ent_t)-1:0] mem;
        logic [`OIQ_NQ-1:0][`OIQ_PTR_W-1:0] head;
        logic [`OIQ_NQ-1:0][`OIQ_PTR_W-1:0] tail;
        logic [`OIQ_NQ-1:0][`OIQ_CNT_W-1:0] count;
        logic out_valid;
        oiq_ent_t out_data;
        logic [1:0] out_queue;
        logic [`OIQ_NPORT-1:0] pause;
        logic ack;
        logic [31:0] rdata;
    } oiq_state_t;

endpackage

// *** logic/oiq_top.sv ***
//
// Operation
// - police each port against its rate limit
// - excess dropped, pause frame requested on port
// - default policy gives best effort class
// - dot1p policy classifies from priority bits
// - dscp policy classifies from dscp field
// - filter policies classify as best effort
// - local packets on network ports are control
// - every packet maps to one of 16 classes
// - three queues, four admission thresholds each
// - default map: control/high1 q2, ef/high2 q1
// - one drop counter per class mapping entry
// - over threshold: drop, bump class counter
// - strict priority service, queue 0 highest
// - service order per queue, class ignored
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
`include "oiq_map.svh"

module oiq_top
    import oiq_pkg::*;
#(
    parameter int RATE_TICK = `OIQ_RATE_TICK
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic en_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic in_valid_i,
    input wire oiq_pkt_t in_pkt_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output oiq_ent_t out_pkt_o,
    output logic [1:0] out_queue_o,
    input wire logic out_ready_i,
    output logic [`OIQ_NPORT-1:0] pause_req_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    oiq_state_t s_q;
    oiq_state_t s_d;

    logic [31:0] wmask;
    logic [31:0] wval;
    logic bus_wr;
    logic bus_rd;

    // ------------------------------------------------------------
    // bus strobes
    // ------------------------------------------------------------
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
        end
    end

    // writes land on the edge that ends the wait
    assign bus_wr = avs_write_i && s_q.ack;
    assign bus_rd = avs_read_i && !s_q.ack;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [`OIQ_BUCKET_W:0] sum;
        logic [3:0] cls;
        logic [2:0] fc;
        logic [1:0] qi;
        logic [1:0] ti;
        logic [`OIQ_CNT_W-1:0] level;
        logic rate_ok;
        logic admit;
        logic [`OIQ_PORT_W-1:0] pt;
        logic [1:0] pol;
        logic [1:0] ev;
        logic pop;
        logic [1:0] popq;
        logic [`OIQ_NQ-1:0] push_v;
        logic [`OIQ_NQ-1:0] pop_v;
        logic refill;
        sum = '0;
        cls = `OIQ_BE_CLASS;
        fc = 3'h0;
        qi = 2'h0;
        ti = 2'h0;
        level = '0;
        rate_ok = 1'b0;
        admit = 1'b0;
        pt = in_pkt_i.port;
        pol = s_q.policy[pt];
        ev = 2'h0;
        pop = 1'b0;
        popq = 2'h0;
        push_v = '0;
        pop_v = '0;
        refill = s_q.tick >= 16'(RATE_TICK - 1);
        s_d = s_q;
        s_d.pause = '0;
        s_d.ack = (avs_read_i || avs_write_i) && !s_q.ack;

        // --------------------------------------------------------
        // token refill per port
        // --------------------------------------------------------
        if (refill) begin
            s_d.tick = 16'h0000;
        end else begin
            s_d.tick = 16'(s_q.tick + 16'h0001);
        end
        for (int p = 0; p < `OIQ_NPORT; p++) begin
            if (refill) begin
                sum = {1'b0, s_q.bucket[p]} + {9'h000, s_q.rate[p]};
                if (sum > {1'b0, s_q.burst[p]}) begin
                    s_d.bucket[p] = s_q.burst[p];
                end else begin
                    s_d.bucket[p] = sum[`OIQ_BUCKET_W-1:0];
                end
            end
        end

        // --------------------------------------------------------
        // classification into 16 classes
        // --------------------------------------------------------
        if (s_q.netport[pt] && in_pkt_i.local_addr) begin
            cls = `OIQ_NC_CLASS;
        end else begin
            // software loads the field type per port in the policy register
            unique case (pol)
                OIQ_POL_DOT1P: begin
                    fc = 3'(3'h7 - in_pkt_i.dot1p);
                    cls = {fc, in_pkt_i.dei};
                end
                OIQ_POL_DSCP: begin
                    fc = 3'(3'h7 - in_pkt_i.dscp[5:3]);
                    cls = {fc, |in_pkt_i.dscp[2:1]};
                end
                OIQ_POL_FILTER: cls = `OIQ_BE_CLASS;
                OIQ_POL_DEFAULT: cls = `OIQ_BE_CLASS;
            endcase
        end

        // --------------------------------------------------------
        // queue and threshold lookup
        // --------------------------------------------------------
        qi = s_q.cmap[cls][3:2];
        ti = s_q.cmap[cls][1:0];
        if (qi == 2'h3) begin
            qi = 2'h0;
        end
        level = s_q.thr[qi][ti];

        // --------------------------------------------------------
        // policing then threshold admission
        // --------------------------------------------------------
        if (in_valid_i && s_q.enable) begin
            rate_ok = {5'h00, in_pkt_i.len} <= s_d.bucket[pt];
            if (!rate_ok) begin
                s_d.pause[pt] = 1'b1;
                ev[`OIQ_IRQ_RATE_BIT] = 1'b1;
            end else begin
                s_d.bucket[pt] = 16'(s_d.bucket[pt] - {5'h00, in_pkt_i.len});
                admit = s_q.count[qi] < level;
                if (admit) begin
                    push_v[qi] = 1'b1;
                    s_d.mem[qi][s_q.tail[qi]] = {pt, in_pkt_i.len};
                    s_d.mem_vld[qi][s_q.tail[qi]] = 1'b1;
                    s_d.tail[qi] = 3'(s_q.tail[qi] + 3'h1);
                end else begin
                    ev[`OIQ_IRQ_QDROP_BIT] = 1'b1;
                    if (s_q.drop[cls] != 16'hFFFF) begin
                        s_d.drop[cls] = 16'(s_q.drop[cls] + 16'h0001);
                    end
                end
            end
        end

        // --------------------------------------------------------
        // strict priority output stage
        // --------------------------------------------------------
        if (!s_q.out_valid || out_ready_i) begin
            s_d.out_valid = 1'b0;
            for (int q = `OIQ_NQ - 1; q >= 0; q--) begin
                if (s_q.count[q] != '0) begin
                    pop = 1'b1;
                    popq = 2'(q);
                end
            end
            if (pop) begin
                // oldest entry leaves first
                pop_v[popq] = 1'b1;
                s_d.out_valid = 1'b1;
                s_d.out_data = s_q.mem[popq][s_q.head[popq]];
                s_d.out_queue = popq;
                s_d.mem_vld[popq][s_q.head[popq]] = 1'b0;
                s_d.head[popq] = 3'(s_q.head[popq] + 3'h1);
            end
        end

        // --------------------------------------------------------
        // queue occupancy
        // --------------------------------------------------------
        for (int q = 0; q < `OIQ_NQ; q++) begin
            if (push_v[q] && !pop_v[q]) begin
                s_d.count[q] = 4'(s_q.count[q] + 4'h1);
            end else if (!push_v[q] && pop_v[q]) begin
                s_d.count[q] = 4'(s_q.count[q] - 4'h1);
            end
        end

        // --------------------------------------------------------
        // register writes
        // --------------------------------------------------------
        wval = avs_writedata_i & wmask;
        if (bus_wr) begin
            unique case (avs_address_i)
                `OIQ_REG_CTRL: begin
                    if (avs_byteenable_i[0]) begin
                        s_d.enable = avs_writedata_i[`OIQ_CTRL_EN_BIT];
                    end
                end
                `OIQ_REG_IRQ_STATUS: begin
                    s_d.irq_status = s_q.irq_status & ~wval[1:0];
                end
                `OIQ_REG_IRQ_MASK: begin
                    if (avs_byteenable_i[0]) begin
                        s_d.irq_mask = avs_writedata_i[1:0];
                    end
                end
                `OIQ_REG_POLICY: begin
                    s_d.policy = (s_q.policy & ~wmask[15:0]) | wval[15:0];
                end
                `OIQ_REG_NETPORT: begin
                    if (avs_byteenable_i[0]) begin
                        s_d.netport = avs_writedata_i[7:0];
                    end
                end
                `OIQ_REG_CMAP_LO: begin
                    s_d.cmap[7:0] = (s_q.cmap[7:0] & ~wmask) | wval;
                end
                `OIQ_REG_CMAP_HI: begin
                    s_d.cmap[15:8] = (s_q.cmap[15:8] & ~wmask) | wval;
                end
                `OIQ_REG_THR0: begin
                    s_d.thr[0] = (s_q.thr[0] & ~wmask[15:0]) | wval[15:0];
                end
                `OIQ_REG_THR1: begin
                    s_d.thr[1] = (s_q.thr[1] & ~wmask[15:0]) | wval[15:0];
                end
                `OIQ_REG_THR2: begin
                    s_d.thr[2] = (s_q.thr[2] & ~wmask[15:0]) | wval[15:0];
                end
                default: begin
                    if (avs_address_i[7:4] == `OIQ_REG_RATE_BASE &&
                            !avs_address_i[3]) begin
                        s_d.rate[avs_address_i[2:0]] =
                            (s_q.rate[avs_address_i[2:0]] & ~wmask[7:0]) |
                            wval[7:0];
                        s_d.burst[avs_address_i[2:0]] =
                            (s_q.burst[avs_address_i[2:0]] &
                            ~wmask[23:8]) | wval[23:8];
                    end
                end
            endcase
        end
        // set wins over a same-cycle clear
        s_d.irq_status = s_d.irq_status | ev;

        // --------------------------------------------------------
        // register reads, sampled on the request edge
        // --------------------------------------------------------
        if (bus_rd) begin
            unique case (avs_address_i)
                `OIQ_REG_CTRL: s_d.rdata = {31'h0, s_q.enable};
                `OIQ_REG_IRQ_STATUS: s_d.rdata = {30'h0, s_q.irq_status};
                `OIQ_REG_IRQ_MASK: s_d.rdata = {30'h0, s_q.irq_mask};
                `OIQ_REG_POLICY: s_d.rdata = {16'h0, s_q.policy};
                `OIQ_REG_NETPORT: s_d.rdata = {24'h0, s_q.netport};
                `OIQ_REG_QLEVEL: s_d.rdata = {20'h0, s_q.count};
                `OIQ_REG_CMAP_LO: s_d.rdata = s_q.cmap[7:0];
                `OIQ_REG_CMAP_HI: s_d.rdata = s_q.cmap[15:8];
                `OIQ_REG_THR0: s_d.rdata = {16'h0, s_q.thr[0]};
                `OIQ_REG_THR1: s_d.rdata = {16'h0, s_q.thr[1]};
                `OIQ_REG_THR2: s_d.rdata = {16'h0, s_q.thr[2]};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    if (avs_address_i[7:4] == `OIQ_REG_RATE_BASE &&
                            !avs_address_i[3]) begin
                        s_d.rdata = {8'h00,
                            s_q.burst[avs_address_i[2:0]],
                            s_q.rate[avs_address_i[2:0]]};
                    end else if (avs_address_i[7:4] ==
                            `OIQ_REG_DROP_BASE) begin
                        s_d.rdata = {16'h0000,
                            s_q.drop[avs_address_i[3:0]]};
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.enable <= `OIQ_CTRL_RST;
            s_q.policy <= `OIQ_POLICY_RST;
            s_q.netport <= `OIQ_NETPORT_RST;
            s_q.cmap[7:0] <= `OIQ_CMAP_LO_RST;
            s_q.cmap[15:8] <= `OIQ_CMAP_HI_RST;
            s_q.thr[0] <= `OIQ_THR_RST;
            s_q.thr[1] <= `OIQ_THR_RST;
            s_q.thr[2] <= `OIQ_THR_RST;
            s_q.rate <= {`OIQ_NPORT{`OIQ_RATE_RST}};
            s_q.burst <= {`OIQ_NPORT{`OIQ_BURST_RST}};
            s_q.bucket <= {`OIQ_NPORT{`OIQ_BURST_RST}};
        end else if (en_i) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_q.ack;
    assign avs_readdata_o = s_q.rdata;
    assign in_ready_o = 1'b1;
    assign out_valid_o = s_q.out_valid;
    assign out_pkt_o = s_q.out_data;
    assign out_queue_o = s_q.out_queue;
    assign pause_req_o = s_q.pause;
    assign irq_o = |(s_q.irq_status & s_q.irq_mask);

endmodule // oiq_top

// *** tb/oiq_checker.sv ***
`timescale 1ns/10ps
`include "oiq_map.svh"

module oiq_checker
    import oiq_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic en_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic in_valid_i,
    input wire oiq_pkt_t in_pkt_i,
    input wire logic in_ready_o,
    input wire logic out_valid_o,
    input wire oiq_ent_t out_pkt_o,
    input wire logic [1:0] out_queue_o,
    input wire logic out_ready_i,
    input wire logic [`OIQ_NPORT-1:0] pause_req_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // ----
    // bus
    // ----
    a_wait_first: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
        else $error("read answered without a wait cycle");
    a_wait_one: assert property (avs_read_i && avs_waitrequest_o && en_i
        |=> !avs_waitrequest_o) else $error("read wait longer than one");
    a_wait_idle: assert property (!avs_read_i && !avs_write_i
        |-> !avs_waitrequest_o) else $error("waitrequest with no request");
    a_rd_stand: assert property (!$past(avs_read_i)
        |-> $stable(avs_readdata_o)) else $error("readdata moved");
    // ----
    // packets
    // ----
    a_in_taken: assert property (in_ready_o)
        else $error("descriptor refused");
    a_pause_port: assert property (|pause_req_o
        |-> pause_req_o == (8'h01 << $past(in_pkt_i.port)))
        else $error("pause on wrong port");
    a_pause_cause: assert property (|pause_req_o
        |-> $past(in_valid_i) && $past(en_i)) else $error("pause unprompted");
    a_out_hold: assert property (out_valid_o && !out_ready_i && en_i
        |=> out_valid_o && $stable(out_pkt_o) && $stable(out_queue_o))
        else $error("output dropped before handshake");
    a_queue_code: assert property (out_valid_o |-> out_queue_o < 2'h3)
        else $error("bad queue number");
    a_en_freeze: assert property (!en_i
        |=> $stable(out_valid_o) && $stable(irq_o) && $stable(pause_req_o))
        else $error("state moved while disabled");
    a_irq_rise: assert property ($rose(irq_o)
        |-> $past(in_valid_i) || $past(avs_write_i))
        else $error("irq rose without cause");

    c_out: cover property (out_valid_o && out_ready_i);
    c_pause: cover property (|pause_req_o);
    c_irq: cover property ($rose(irq_o));
endmodule // oiq_checker

// *** tb/oiq_fwd_sink.sv ***
`timescale 1ns/10ps

module oiq_fwd_sink
    import oiq_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic stall_i,
    input wire logic out_valid_i,
    input wire oiq_ent_t out_pkt_i,
    input wire logic [1:0] out_queue_i,
    output logic ready_o
);
    logic [1:0] q_log[$];
    logic [2:0] p_log[$];

    // log every handshake; stall holds the sink not ready
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ready_o <= 1'b0;
        end else begin
            if (out_valid_i && ready_o) begin
                q_log.push_back(out_queue_i);
                p_log.push_back(out_pkt_i.port);
            end
            ready_o <= !stall_i;
        end
    end
endmodule // oiq_fwd_sink

// *** tb/test_oiq_top.sv ***
`timescale 1ns/10ps
`include "oiq_map.svh"

module test_oiq_top
    import oiq_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic en_i = 1'b1;
    logic stall = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, in_ready_o, out_valid_o, out_ready_i, irq_o;
    logic in_valid_i = 1'b0;
    oiq_pkt_t in_pkt_i = '0;
    oiq_ent_t out_pkt_o;
    logic [1:0] out_queue_o;
    logic [7:0] pause_req_o;
    logic [7:0] pause_seen = 8'h00;
    logic [31:0] rd;
    logic [1:0] exp_q[7] = '{0, 0, 0, 0, 1, 2, 2};
    logic [2:0] exp_p[7] = '{0, 0, 0, 2, 1, 1, 4};
    int bad_count = 0;
    int num_checks = 0;
    int n;

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) pause_seen <= pause_seen | pause_req_o;

    oiq_top #(.RATE_TICK(1)) oiq_top_i (.clk_i, .resetn_i, .en_i,
        .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .in_valid_i,
        .in_pkt_i, .in_ready_o, .out_valid_o, .out_pkt_o, .out_queue_o,
        .out_ready_i, .pause_req_o, .irq_o);
    oiq_fwd_sink oiq_fwd_sink_i (.clk_i, .resetn_i, .stall_i(stall),
        .out_valid_i(out_valid_o), .out_pkt_i(out_pkt_o),
        .out_queue_i(out_queue_o), .ready_o(out_ready_i));

    // ----
    // tasks
    // ----
    task automatic chk(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        // hold until waitrequest is seen low at a rising edge
        do begin
            @(posedge clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 50);
        if (k >= 50) begin
            bad_count++;
        end
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic send(input logic [2:0] port, pcp, input logic dei,
                        input logic [5:0] dscp, input logic loc,
                        input logic [10:0] len);
        in_pkt_i <= '{port, len, pcp, dei, dscp, loc};
        in_valid_i <= 1'b1;
        @(posedge clk_i);
    endtask

    // ----
    // sequence
    // ----
    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        bus(0, `OIQ_REG_CTRL, 0);
        chk("ctrl", rd, 32'h1);
        bus(0, `OIQ_REG_CMAP_LO, 0);
        chk("cmap_lo", rd, 32'h4567_89AB);
        bus(0, `OIQ_REG_THR0, 0);
        chk("thr0", rd, 32'h8642);
        bus(0, 8'hFF, 0);
        chk("unmapped", rd, 32'h0);
        for (int c = 0; c < 16; c++) begin
            bus(0, {4'h3, c[3:0]}, 0);
            chk("drop init", rd, 32'h0);
        end
        // sink stalled: output stage holds one, fourth packet dropped
        repeat (4) send(0, 0, 0, 0, 0, 64);
        in_valid_i <= 1'b0;
        bus(0, `OIQ_REG_QLEVEL, 0);
        chk("qlevel a", rd, 32'h2);
        bus(0, 8'h3E, 0);
        chk("drop be", rd, 32'h1);
        bus(0, `OIQ_REG_IRQ_STATUS, 0);
        chk("status", rd, 32'h2);
        bus(1, `OIQ_REG_IRQ_MASK, 32'h2);
        @(posedge clk_i);
        chk("irq on", irq_o, 1'b1);
        bus(1, `OIQ_REG_IRQ_STATUS, 32'h2);
        @(posedge clk_i);
        chk("irq clear", irq_o, 1'b0);
        bus(1, `OIQ_REG_IRQ_MASK, 32'h0);
        // packets offered while frozen must leave no trace
        en_i <= 1'b0;
        repeat (3) send(0, 0, 0, 0, 0, 64);
        in_valid_i <= 1'b0;
        en_i <= 1'b1;
        // per-port policies, then drain in priority order
        bus(1, `OIQ_REG_POLICY, 32'hE4);
        bus(1, `OIQ_REG_NETPORT, 32'h10);
        send(1, 7, 0, 0, 0, 64);
        send(1, 5, 1, 0, 0, 64);
        send(2, 0, 0, 6'h0A, 0, 64);
        send(3, 7, 0, 0, 0, 64);
        send(4, 0, 0, 0, 1, 64);
        in_valid_i <= 1'b0;
        bus(0, 8'h3E, 0);
        chk("drop filter", rd, 32'h2);
        chk("irq masked", irq_o, 1'b0);
        bus(0, `OIQ_REG_QLEVEL, 0);
        chk("qlevel b", rd, 32'h213);
        stall <= 1'b0;
        for (n = 0; n < 100 && oiq_fwd_sink_i.q_log.size() < 7; n++) begin
            @(posedge clk_i);
        end
        chk("drained", oiq_fwd_sink_i.q_log.size(), 7);
        for (int i = 0; i < 7; i++) begin
            chk("queue", oiq_fwd_sink_i.q_log[i], exp_q[i]);
            chk("port", oiq_fwd_sink_i.p_log[i], exp_p[i]);
        end
        // zero rate and burst on port 5, so the bucket empties at the next refill
        bus(1, 8'h25, 32'h0);
        for (n = 0; n < 40 && pause_seen == 8'h00; n++) begin
            send(5, 0, 0, 0, 0, 11'h7FF);
        end
        in_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("pause", pause_seen, 8'h20);
        bus(0, `OIQ_REG_IRQ_STATUS, 0);
        chk("rate status", rd[0], 1'b1);
        close_out();
    end

    initial begin
        #2000000;
        bad_count++;
        close_out();
    end
endmodule // test_oiq_top

bind oiq_top oiq_checker oiq_checker_i (.clk_i, .resetn_i, .en_i,
    .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
    .in_valid_i, .in_pkt_i, .in_ready_o, .out_valid_o, .out_pkt_o,
    .out_queue_o, .out_ready_i, .pause_req_o, .irq_o);
